/* rtl/pots_pkg.sv */
`default_nettype none
package pots_pkg;
    localparam int GROUPS = 4;
    localparam int GROUP_W = 4;
    localparam int PINS = GROUPS * GROUP_W;
    localparam int SEL_W = 2;
    localparam int CHANNELS = 4;

    localparam logic [7:0] OFS_GAP_MODE = 8'h00;
    localparam logic [7:0] OFS_CHAN_SEL = 8'h04;
    localparam logic [7:0] OFS_NEXT_BITS = 8'h08;
    localparam logic [7:0] OFS_NEXT_EN = 8'h0C;
    localparam logic [7:0] OFS_PIN_STATE = 8'h10;

    localparam logic [3:0] GAP_MODE_RST = 4'h0;
    localparam logic [3:0] GAP_MODE_RSVD = 4'hF;
    localparam logic [7:0] CHAN_SEL_RST = 8'hFF;
    localparam logic [15:0] NEXT_BITS_RST = 16'h0000;
    localparam logic [15:0] NEXT_EN_RST = 16'h0000;
    localparam logic [15:0] PIN_RST = 16'h0000;
endpackage
`default_nettype wire

/* rtl/pots_top.sv */
// The placing of the registers and the APB slave port were decided locally.
`default_nettype none
module pots_top #(
    parameter int ADDR_W = 8
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [3:0] cmp_a,
    input wire logic [3:0] cmp_b,
    output logic [15:0] pattern_pin,
    output logic [15:0] pattern_pin_en
);
    logic [1:0] grp0_chan_sel_reg;
    logic [1:0] grp1_chan_sel_reg;
    logic [1:0] grp2_chan_sel_reg;
    logic [1:0] grp3_chan_sel_reg;
    logic grp0_gap_mode_reg;
    logic grp1_gap_mode_reg;
    logic grp2_gap_mode_reg;
    logic grp3_gap_mode_reg;
    logic [3:0] grp0_next_bits_reg;
    logic [3:0] grp1_next_bits_reg;
    logic [3:0] grp2_next_bits_reg;
    logic [3:0] grp3_next_bits_reg;
    logic [3:0] grp0_next_en_reg;
    logic [3:0] grp1_next_en_reg;
    logic [3:0] grp2_next_en_reg;
    logic [3:0] grp3_next_en_reg;
    logic [3:0] grp0_pin_reg;
    logic [3:0] grp1_pin_reg;
    logic [3:0] grp2_pin_reg;
    logic [3:0] grp3_pin_reg;
    logic [3:0] gap_mode;
    logic [7:0] group_trigger_channel_select;
    logic [15:0] next_bits;
    logic [15:0] next_en;
    logic [15:0] pin_state;
    logic [31:0] rdata_reg;
    logic [31:0] rdata_next;
    logic [3:0] trig_a;
    logic [3:0] trig_b;
    logic addr_hit;
    logic wr_en;
    logic wr_gap_mode;
    logic wr_chan_sel;
    logic [1:0] wr_next_bits;
    logic [1:0] wr_next_en;
    logic [7:0] addr_lo;

    // One strobe out of the four timer channels
    function automatic logic pick_channel(input logic [3:0] strobes, input logic [1:0] sel);
        return strobes[sel];
    endfunction

    function automatic logic known_addr(input logic [7:0] a);
        return a == pots_pkg::OFS_GAP_MODE || a == pots_pkg::OFS_CHAN_SEL ||
               a == pots_pkg::OFS_NEXT_BITS || a == pots_pkg::OFS_NEXT_EN ||
               a == pots_pkg::OFS_PIN_STATE;
    endfunction

    assign addr_lo = 8'(paddr);
    assign addr_hit = known_addr(addr_lo) && (paddr == ADDR_W'(addr_lo));
    assign pready = psel & penable;
    assign pslverr = psel & penable & ~addr_hit;
    assign wr_en = psel & penable & pwrite & addr_hit;
    assign wr_gap_mode = wr_en && addr_lo == pots_pkg::OFS_GAP_MODE && pstrb[0];
    assign wr_chan_sel = wr_en && addr_lo == pots_pkg::OFS_CHAN_SEL && pstrb[0];
    // Lane 0 carries groups 0 and 1, lane 1 groups 2 and 3
    assign wr_next_bits = (wr_en && addr_lo == pots_pkg::OFS_NEXT_BITS) ? pstrb[1:0] : 2'h0;
    assign wr_next_en = (wr_en && addr_lo == pots_pkg::OFS_NEXT_EN) ? pstrb[1:0] : 2'h0;
    assign gap_mode = {grp3_gap_mode_reg, grp2_gap_mode_reg, grp1_gap_mode_reg, grp0_gap_mode_reg};
    assign group_trigger_channel_select = {grp3_chan_sel_reg, grp2_chan_sel_reg, grp1_chan_sel_reg,
                                           grp0_chan_sel_reg};
    assign next_bits = {grp3_next_bits_reg, grp2_next_bits_reg, grp1_next_bits_reg, grp0_next_bits_reg};
    assign next_en = {grp3_next_en_reg, grp2_next_en_reg, grp1_next_en_reg, grp0_next_en_reg};
    assign pin_state = {grp3_pin_reg, grp2_pin_reg, grp1_pin_reg, grp0_pin_reg};
    assign prdata = rdata_reg;
    assign pattern_pin = pin_state;
    assign pattern_pin_en = next_en;

    // Channel routing per group
    always_comb begin
        trig_a[0] = pick_channel(cmp_a, grp0_chan_sel_reg);
        trig_b[0] = pick_channel(cmp_b, grp0_chan_sel_reg);
        trig_a[1] = pick_channel(cmp_a, grp1_chan_sel_reg);
        trig_b[1] = pick_channel(cmp_b, grp1_chan_sel_reg);
        trig_a[2] = pick_channel(cmp_a, grp2_chan_sel_reg);
        trig_b[2] = pick_channel(cmp_b, grp2_chan_sel_reg);
        trig_a[3] = pick_channel(cmp_a, grp3_chan_sel_reg);
        trig_b[3] = pick_channel(cmp_b, grp3_chan_sel_reg);
    end

    // Gap mode: falling bits move at match A and rising bits at match B, so
    // complementary pins never overlap high while B lags A.
    function automatic logic [pots_pkg::GROUP_W-1:0] group_pins(
        input logic [pots_pkg::GROUP_W-1:0] cur,
        input logic [pots_pkg::GROUP_W-1:0] nxt,
        input logic [pots_pkg::GROUP_W-1:0] en,
        input logic gap,
        input logic hit_a,
        input logic hit_b
    );
        logic [pots_pkg::GROUP_W-1:0] res;
        res = cur;
        for (int i = 0; i < pots_pkg::GROUP_W; i++) begin
            if (en[i]) begin
                if (!gap) begin
                    if (hit_a) begin
                        res[i] = nxt[i];
                    end
                end else if (hit_a && !nxt[i]) begin
                    res[i] = 1'h0;
                end else if (hit_b && nxt[i]) begin
                    res[i] = 1'h1;
                end
            end
        end
        return res;
    endfunction

    // Group 0, pattern pins 3 to 0
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            grp0_gap_mode_reg <= pots_pkg::GAP_MODE_RST[0];
        end else if (wr_gap_mode) begin
            grp0_gap_mode_reg <= pwdata[0];
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            grp0_chan_sel_reg <= pots_pkg::CHAN_SEL_RST[1:0];
        end else if (wr_chan_sel) begin
            grp0_chan_sel_reg <= pwdata[1:0];
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            grp0_next_bits_reg <= pots_pkg::NEXT_BITS_RST[3:0];
        end else if (wr_next_bits[0]) begin
            grp0_next_bits_reg <= pwdata[3:0];
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            grp0_next_en_reg <= pots_pkg::NEXT_EN_RST[3:0];
        end else if (wr_next_en[0]) begin
            grp0_next_en_reg <= pwdata[3:0];
        end
    end

    // A trigger in the cycle of a register write still sees the old settings
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            grp0_pin_reg <= pots_pkg::PIN_RST[3:0];
        end else begin
            grp0_pin_reg <= group_pins(grp0_pin_reg, grp0_next_bits_reg, grp0_next_en_reg, grp0_gap_mode_reg,
                                       trig_a[0], trig_b[0]);
        end
    end

    // Group 1, pattern pins 7 to 4
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            grp1_gap_mode_reg <= pots_pkg::GAP_MODE_RST[1];
        end else if (wr_gap_mode) begin
            grp1_gap_mode_reg <= pwdata[1];
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            grp1_chan_sel_reg <= pots_pkg::CHAN_SEL_RST[3:2];
        end else if (wr_chan_sel) begin
            grp1_chan_sel_reg <= pwdata[3:2];
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            grp1_next_bits_reg <= pots_pkg::NEXT_BITS_RST[7:4];
        end else if (wr_next_bits[0]) begin
            grp1_next_bits_reg <= pwdata[7:4];
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            grp1_next_en_reg <= pots_pkg::NEXT_EN_RST[7:4];
        end else if (wr_next_en[0]) begin
            grp1_next_en_reg <= pwdata[7:4];
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            grp1_pin_reg <= pots_pkg::PIN_RST[7:4];
        end else begin
            grp1_pin_reg <= group_pins(grp1_pin_reg, grp1_next_bits_reg, grp1_next_en_reg, grp1_gap_mode_reg,
                                       trig_a[1], trig_b[1]);
        end
    end

    // Group 2, pattern pins 11 to 8
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            grp2_gap_mode_reg <= pots_pkg::GAP_MODE_RST[2];
        end else if (wr_gap_mode) begin
            grp2_gap_mode_reg <= pwdata[2];
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            grp2_chan_sel_reg <= pots_pkg::CHAN_SEL_RST[5:4];
        end else if (wr_chan_sel) begin
            grp2_chan_sel_reg <= pwdata[5:4];
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            grp2_next_bits_reg <= pots_pkg::NEXT_BITS_RST[11:8];
        end else if (wr_next_bits[1]) begin
            grp2_next_bits_reg <= pwdata[11:8];
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            grp2_next_en_reg <= pots_pkg::NEXT_EN_RST[11:8];
        end else if (wr_next_en[1]) begin
            grp2_next_en_reg <= pwdata[11:8];
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            grp2_pin_reg <= pots_pkg::PIN_RST[11:8];
        end else begin
            grp2_pin_reg <= group_pins(grp2_pin_reg, grp2_next_bits_reg, grp2_next_en_reg, grp2_gap_mode_reg,
                                       trig_a[2], trig_b[2]);
        end
    end

    // Group 3, pattern pins 15 to 12
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            grp3_gap_mode_reg <= pots_pkg::GAP_MODE_RST[3];
        end else if (wr_gap_mode) begin
            grp3_gap_mode_reg <= pwdata[3];
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            grp3_chan_sel_reg <= pots_pkg::CHAN_SEL_RST[7:6];
        end else if (wr_chan_sel) begin
            grp3_chan_sel_reg <= pwdata[7:6];
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            grp3_next_bits_reg <= pots_pkg::NEXT_BITS_RST[15:12];
        end else if (wr_next_bits[1]) begin
            grp3_next_bits_reg <= pwdata[15:12];
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            grp3_next_en_reg <= pots_pkg::NEXT_EN_RST[15:12];
        end else if (wr_next_en[1]) begin
            grp3_next_en_reg <= pwdata[15:12];
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            grp3_pin_reg <= pots_pkg::PIN_RST[15:12];
        end else begin
            grp3_pin_reg <= group_pins(grp3_pin_reg, grp3_next_bits_reg, grp3_next_en_reg, grp3_gap_mode_reg,
                                       trig_a[3], trig_b[3]);
        end
    end

    // Read data is captured in the setup cycle so prdata comes from a flop
    always_comb begin
        rdata_next = 32'h0000_0000;
        case (addr_lo)
            pots_pkg::OFS_GAP_MODE: rdata_next = {24'h00_0000, pots_pkg::GAP_MODE_RSVD, gap_mode};
            pots_pkg::OFS_CHAN_SEL: rdata_next = {24'h00_0000, group_trigger_channel_select};
            pots_pkg::OFS_NEXT_BITS: rdata_next = {16'h0000, next_bits};
            pots_pkg::OFS_NEXT_EN: rdata_next = {16'h0000, next_en};
            pots_pkg::OFS_PIN_STATE: rdata_next = {16'h0000, pin_state};
            default: rdata_next = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rdata_reg <= 32'h0000_0000;
        end else if (psel && !penable) begin
            rdata_reg <= addr_hit ? rdata_next : 32'h0000_0000;
        end
    end
endmodule
`default_nettype wire

/* sim/pots_asserts.sv */
`default_nettype none
module pots_asserts (
    input wire logic clk, input wire logic rst_b, input wire logic psel, input wire logic penable,
    input wire logic pwrite, input wire logic [7:0] paddr, input wire logic [31:0] pwdata,
    input wire logic [3:0] cmp_a, input wire logic [3:0] cmp_b, input wire logic [15:0] pattern_pin
);
    logic [7:0] s_reg;
    logic [3:0] g_reg;
    logic [15:0] n_reg;
    logic [15:0] e_reg;
    wire logic w = psel && penable && pwrite;
    wire logic [3:0] a = {cmp_a[s_reg[7:6]], cmp_a[s_reg[5:4]], cmp_a[s_reg[3:2]], cmp_a[s_reg[1:0]]};
    wire logic [3:0] b = {cmp_b[s_reg[7:6]], cmp_b[s_reg[5:4]], cmp_b[s_reg[3:2]], cmp_b[s_reg[1:0]]};
    // Shadows assume full byte lanes
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) {g_reg, s_reg} <= 12'h0FF;
        else if (w && paddr == 8'h04) s_reg <= pwdata[7:0];
        else if (w && paddr == 8'h00) g_reg <= pwdata[3:0];
    end
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) {n_reg, e_reg} <= 32'h0000_0000;
        else if (w && paddr == 8'h08) n_reg <= pwdata[15:0];
        else if (w && paddr == 8'h0C) e_reg <= pwdata[15:0];
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);
    property p_s0; !a[0] && !b[0] |=> $stable(pattern_pin[3:0]); endproperty
    a_s0: assert property (p_s0) else $error("group 0 moved");
    property p_s1; !a[1] && !b[1] |=> $stable(pattern_pin[7:4]); endproperty
    a_s1: assert property (p_s1) else $error("group 1 moved");
    property p_s2; !a[2] && !b[2] |=> $stable(pattern_pin[11:8]); endproperty
    a_s2: assert property (p_s2) else $error("group 2 moved");
    property p_s3; !a[3] && !b[3] |=> $stable(pattern_pin[15:12]); endproperty
    a_s3: assert property (p_s3) else $error("group 3 moved");
    property p_n0; !g_reg[0] && !a[0] |=> $stable(pattern_pin[3:0]); endproperty
    a_n0: assert property (p_n0) else $error("group 0 moved off A");
    property p_n1; !g_reg[1] && !a[1] |=> $stable(pattern_pin[7:4]); endproperty
    a_n1: assert property (p_n1) else $error("group 1 moved off A");
    property p_n2; !g_reg[2] && !a[2] |=> $stable(pattern_pin[11:8]); endproperty
    a_n2: assert property (p_n2) else $error("group 2 moved off A");
    property p_n3; !g_reg[3] && !a[3] |=> $stable(pattern_pin[15:12]); endproperty
    a_n3: assert property (p_n3) else $error("group 3 moved off A");
    property p_u0;
        !g_reg[0] && a[0] |=> pattern_pin[3:0] ==
            (($past(n_reg[3:0]) & $past(e_reg[3:0])) | ($past(pattern_pin[3:0]) & ~$past(e_reg[3:0])));
    endproperty
    a_u0: assert property (p_u0) else $error("group 0 missed compare A");
    c_b: cover property (g_reg[0] && b[0]);
    c_a: cover property (!g_reg[0] && a[0]);
    c_w: cover property (w && paddr == 8'h04);
endmodule
bind pots_top pots_asserts pots_asserts_inst (.*);
`default_nettype wire

/* sim/pots_timer.sv */
`default_nettype none
module pots_timer (
    input wire logic clk,
    input wire logic [7:0] go,
    output logic [7:0] cmp
);
    // Registered so each match is a clean one-cycle strobe
    always @(posedge clk) cmp <= go;
endmodule
`default_nettype wire

/* sim/pattern_output_trigger_select_test.sv */
`default_nettype none
module pattern_output_trigger_select_test;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 1'h0, rst_b = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0, pready;
    logic [7:0] paddr = 8'h00, go = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pslverr, err;
    logic [15:0] pattern_pin, pattern_pin_en;
    wire logic [7:0] cmp;
    int miscompares = 0, compares = 0;
    always #10 clk = ~clk;
    pots_timer pots_timer_inst (.clk(clk), .go(go), .cmp(cmp));
    pots_top pots_top_inst (.clk(clk), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(4'hF), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .cmp_a(cmp[3:0]), .cmp_b(cmp[7:4]), .pattern_pin(pattern_pin), .pattern_pin_en(pattern_pin_en));
    task automatic test_done;
        if (miscompares == 0 && compares > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (g !== e) $display("Error %s expected %h seen %h", n, e, g);
        if (g !== e) miscompares++;
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        {psel, penable, pwrite, paddr, pwdata} <= {2'h2, w, a, d};
        @(posedge clk);
        penable <= 1'h1;
        do @(posedge clk); while (pready !== 1'h1);
        rd = prdata;
        err = pslverr;
        {psel, penable} <= 2'h0;
    endtask
    task automatic fire(input logic [7:0] g, input logic [15:0] e);
        go <= g;
        @(posedge clk) go <= 8'h00;
        repeat (2) @(posedge clk);
        chk("pins", {16'h0000, e}, {16'h0000, pattern_pin});
    endtask
    task automatic t_select;
        apb(1'h0, 8'h04, 32'h0);
        chk("chan_sel", 32'h0000_00FF, rd);
        apb(1'h1, 8'h08, 32'h0000_3CA5);
        apb(1'h1, 8'h0C, 32'h0000_0FFF);
        fire(8'h08, 16'h0CA5);
        apb(1'h1, 8'h04, 32'h0000_00E4);
        apb(1'h1, 8'h08, 32'h0000_C35A);
        fire(8'h08, 16'h0CA5);
        fire(8'h04, 16'h03A5);
        fire(8'h02, 16'h0355);
        fire(8'h01, 16'h035A);
    endtask
    task automatic t_gap;
        apb(1'h1, 8'h00, 32'h0000_0003);
        apb(1'h1, 8'h08, 32'h0000_0CA5);
        fire(8'h07, 16'h0C00);
        fire(8'h70, 16'h0CA5);
    endtask
    task automatic t_grp3;
        apb(1'h1, 8'h0C, 32'h0000_FFFF);
        apb(1'h1, 8'h00, 32'h0000_0008);
        apb(1'h1, 8'h08, 32'h0000_5CA5);
        fire(8'h08, 16'h0CA5);
        fire(8'h80, 16'h5CA5);
        apb(1'h1, 8'h00, 32'h0000_0000);
        apb(1'h1, 8'h04, 32'h0000_0024);
        apb(1'h1, 8'h08, 32'h0000_ACA5);
        fire(8'h08, 16'h5CA5);
        fire(8'h01, 16'hACA5);
    endtask
    task automatic t_bus;
        apb(1'h0, 8'h00, 32'h0);
        chk("gap_mode", 32'h0000_00F0, rd);
        chk("slverr", 32'h0000_0000, {31'h0, err});
        apb(1'h0, 8'h10, 32'h0);
        chk("pin_state", 32'h0000_ACA5, rd);
        chk("pin_en", 32'h0000_FFFF, {16'h0000, pattern_pin_en});
        apb(1'h0, 8'h14, 32'h0);
        chk("slverr", 32'h0000_0001, {31'h0, err});
        chk("unmapped", 32'h0000_0000, rd);
    endtask
    initial begin
        repeat (5) @(posedge clk);
        rst_b <= 1'h1;
        t_select();
        t_gap();
        t_grp3();
        t_bus();
        test_done();
    end
    initial begin
        #20us;
        miscompares++;
        test_done();
    end
endmodule
`default_nettype wire
